// ===== bench/epp_ext_model.sv
// far-end device model: answers port reads on the data pins
`timescale 1ns/1ns
module epp_ext_model #(
    parameter logic [31:0] PAT = 32'hA5A5_5A5A
) (
    input wire logic mclk, // system clock
    input wire logic extRd, // read strobe
    input wire logic [31:0] extAddr, // address pins
    output logic [31:0] extDin // data pins
);
    initial extDin = 32'h0000_0000;
    // data is live only while the strobe is up, whatever the port clock does
    always @(posedge mclk) begin
        if (extRd) begin
            extDin <= extAddr ^ PAT;
        end else begin
            // released bus keeps changing so a stale sample never matches
            extDin <= ~extDin;
        end
    end
endmodule

// ===== bench/tb.sv
// self-checking bench for the external parallel port
`timescale 1ns/1ns
module tb import epp_pkg::*;;
    localparam logic [31:0] PAT = 32'hA5A5_5A5A;
    logic mclk = 0, rst_n = 0, priReq = 0, priWr = 0, secReq = 0, secWr = 0;
    logic cfgWe = 0, cfgFromSec = 0, nbrPop = 0, wrPrev = 0, rdPrev = 0, d, e;
    logic [31:0] priAddr = '0, priWdata = '0, secAddr = '0, secWdata = '0, cfgData = '0;
    logic [31:0] extDin, rdData, extAddr;
    logic [3:0] cfgIdx = '0;
    logic priReady, priRvalid, priErr, secReady, secErr, cfgDenied;
    logic gpSel, sdramSel, hostSel, hostWide, extRd, extWr, nbrValid, irqPrimary;
    logic [31:0] nbrData;
    logic [3:0] irqStatus;
    logic [31:0] wrLog[$];
    int err_total = 0, n_compared = 0, wrAtRead = -1, st, st2;
    always #4 mclk = ~mclk;
    epp_port dut_u (.mclk, .rst_n, .priReq, .priWr, .priAddr, .priWdata, .priReady,
        .priRvalid, .priErr, .secReq, .secWr, .secAddr, .secWdata, .secReady,
        .secRvalid(), .secErr, .rdData, .cfgWe, .cfgFromSec, .cfgIdx, .cfgData,
        .cfgDenied, .nbrPop, .nbrData, .nbrValid, .irqStatus, .irqPrimary,
        .irqSecondary(), .dmaReq20(), .dmaReq22(), .gpSel, .sdramSel, .hostSel,
        .hostWide, .extAddr, .extDout(), .extDoe_n(), .extDin, .extRd, .extWr,
        .extFrame(), .extClk());
    epp_ext_model #(.PAT(PAT)) ext_u (.mclk, .extRd, .extAddr, .extDin);
    always @(posedge mclk) begin
        if (extWr && !wrPrev) wrLog.push_back(extAddr);
        if (extRd && !rdPrev) wrAtRead = wrLog.size();
        wrPrev <= extWr;
        rdPrev <= extRd;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task cfg(input logic sec, input logic [3:0] ix, input logic [31:0] v, output logic dn);
        @(negedge mclk);
        cfgWe = 1;
        cfgFromSec = sec;
        cfgIdx = ix;
        cfgData = v;
        @(negedge mclk);
        cfgWe = 0;
        dn = cfgDenied;
    endtask
    // holds the request until the edge that takes it, then releases it
    task req(input logic who, input logic wr, input logic [31:0] a, output logic er,
        output int n);
        n = 0;
        @(negedge mclk);
        if (who) begin
            secReq = 1;
            secWr = wr;
            secAddr = a;
            secWdata = ~a;
        end else begin
            priReq = 1;
            priWr = wr;
            priAddr = a;
            priWdata = ~a;
        end
        #1;
        while (!(who ? secReady : priReady) && n < 500) begin
            @(negedge mclk);
            #1;
            n++;
        end
        @(negedge mclk);
        er = who ? secErr : priErr;
        priReq = 0;
        secReq = 0;
    endtask
    task t_owner;
        cfg(1, IDX_PORT_CFG, 32'h0000_0003, d);
        chk(d, 1);
        chk(hostWide, 0);
        cfg(0, IDX_WINDOW, 32'h0000_0000, d);
        chk(d, 1);
        cfg(1, IDX_WINDOW, 32'h0000_0000, d);
        chk(d, 0);
    endtask
    task t_modes;
        for (int i = 0; i < 4; i++) begin
            cfg(0, IDX_PORT_CFG, 32'(i), d);
            chk(hostWide, i == 3);
            req(0, 1, 32'h0000_0100, e, st);
            for (int k = 0; k < 300 && !extWr; k++) @(negedge mclk);
            // only one engine may own the pins in each mode
            chk({gpSel, sdramSel, hostSel}, i == 0 ? 4 : i == 1 ? 2 : 1);
            for (int k = 0; k < 300 && extWr; k++) @(negedge mclk);
        end
        cfg(0, IDX_PORT_CFG, 32'h0000_0000, d);
    endtask
    task t_fifo;
        cfg(0, IDX_BAUD, 32'h0000_0007, d);
        wrLog.delete();
        for (int i = 0; i < 6; i++) begin
            req(0, 1, 32'(i * 16), e, st);
            if (i < 4) chk(st, 0);
        end
        st2 = st;
        chk(st2 > 0, 1);
        req(0, 0, 32'h0000_0300, e, st);
        for (int k = 0; k < 1000 && !priRvalid; k++) @(negedge mclk);
        chk(priRvalid, 1);
        chk(rdData, 32'h0000_0300 ^ PAT);
        chk(wrAtRead, 6);
        for (int i = 0; i < 6; i++) chk(wrLog[i], 32'(i * 16));
    endtask
    task t_protect;
        // space 1 taken away from the secondary core only
        cfg(0, IDX_PROTECT, 32'h0000_00F7, d);
        req(1, 1, 32'h4000_0000, e, st);
        chk(e, 1);
        req(0, 1, 32'h4000_0000, e, st);
        chk(e, 0);
        // now space 1 taken away from the primary core
        cfg(0, IDX_PROTECT, 32'h0000_00FB, d);
        req(0, 1, 32'h4000_0000, e, st);
        chk(e, 1);
        cfg(0, IDX_PROTECT, 32'h0000_00FF, d);
    endtask
    task t_bg;
        cfg(0, IDX_IRQ_MASK, 32'h0000_0001, d);
        cfg(0, IDX_RD_SIZE0, 32'h0000_0002, d);
        cfg(0, IDX_RD_ADDR0, 32'h0000_1000, d);
        cfg(0, IDX_RD_COUNT0, 32'h0000_0002, d);
        for (int w = 0; w < 2; w++) begin
            for (int k = 0; k < 1000 && !nbrValid; k++) @(negedge mclk);
            chk(nbrData, (32'h0000_1000 + 32'(4 * w)) ^ PAT);
            @(negedge mclk);
            chk(irqPrimary, 1);
            nbrPop = 1;
            @(negedge mclk);
            nbrPop = 0;
        end
        chk(irqStatus[IRQ_NBR_DATA], 1);
        chk(irqStatus[IRQ_BG_DONE], 1);
        cfg(0, IDX_IRQ_CLEAR, 32'h0000_000F, d);
        chk(irqStatus, 0);
    endtask
    task t_arb;
        @(negedge mclk);
        priReq = 1;
        secReq = 1;
        priWr = 1;
        secWr = 1;
        #1;
        chk({priReady, secReady}, 2);
        @(negedge mclk);
        priReq = 0;
        for (int k = 0; k < 300 && !secReady; k++) @(negedge mclk);
        @(negedge mclk);
        secReq = 0;
        cfg(1, IDX_WINDOW, 32'h0000_0014, d);
        req(1, 1, 32'h0000_0040, e, st);
        req(0, 1, 32'h0000_0080, e, st);
        chk(st > 15, 1);
        cfg(1, IDX_WINDOW, 32'h0000_0000, d);
    endtask
    task summarize;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1;
        t_owner();
        t_modes();
        t_fifo();
        t_protect();
        t_arb();
        t_bg();
        summarize();
    end
endmodule

// ===== hw/epp_pkg.sv
// constants shared by the external parallel port
package epp_pkg;
    // configuration register indices on the config write port
    localparam logic [3:0] IDX_PORT_CFG = 4'h0;
    localparam logic [3:0] IDX_BAUD = 4'h1;
    localparam logic [3:0] IDX_FRAME = 4'h2;
    localparam logic [3:0] IDX_PROTECT = 4'h3;
    localparam logic [3:0] IDX_WINDOW = 4'h4;
    localparam logic [3:0] IDX_ADDR_MAP = 4'h5;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h6;
    localparam logic [3:0] IDX_IRQ_CLEAR = 4'h7;
    localparam logic [3:0] IDX_RD_COUNT0 = 4'h8;
    localparam logic [3:0] IDX_RD_COUNT1 = 4'h9;
    localparam logic [3:0] IDX_RD_ADDR0 = 4'hA;
    localparam logic [3:0] IDX_RD_ADDR1 = 4'hB;
    localparam logic [3:0] IDX_RD_SIZE0 = 4'hC;
    localparam logic [3:0] IDX_RD_SIZE1 = 4'hD;
    // port_config_reg fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_GATED_BIT = 4;
    localparam int CFG_MAP_EN_BIT = 5;
    // operating modes in the mode field
    localparam logic [1:0] MODE_GP = 2'h0;
    localparam logic [1:0] MODE_SDRAM = 2'h1;
    localparam logic [1:0] MODE_HOST8 = 2'h2;
    localparam logic [1:0] MODE_HOST16 = 2'h3;
    // frame length limits in transactions
    localparam logic [4:0] FRAME_MIN = 5'h01;
    localparam logic [4:0] FRAME_MAX = 5'h1E;
    // interrupt status bits
    localparam int IRQ_NBR_DATA = 0;
    localparam int IRQ_BLOCKED = 1;
    localparam int IRQ_WF_EMPTY = 2;
    localparam int IRQ_BG_DONE = 3;
    // reset values
    localparam logic [31:0] RST_PORT_CFG = 32'h0000_0000;
    localparam logic [15:0] RST_BAUD = 16'h0000;
    localparam logic [7:0] RST_PROTECT = 8'hFF;
    typedef enum logic [1:0] {ENG_WR, ENG_RD, ENG_BG} epp_kind_t;
    typedef enum logic {ENG_IDLE, ENG_RUN} epp_state_t;
endpackage

// ===== hw/epp_port.sv
// external parallel bus port: arbitration, protection, fifos, engine, clock and frame
//
// Contract
// - by default, primary core wins when both cores request together.
// - with a window set, secondary owns the bus; primary stalls meanwhile.
// - each chip-select space owned by primary, secondary or both; others blocked.
// - only secondary writes window settings; primary writes all other configuration.
// - accepted cycles steered to general, SDRAM or host engine by mode.
// - writes queue in a four-word fifo; stall while it is full or a blocking read is pending.
// - with read count zero, reads stall the requester until data returns.
// - nonzero read count starts background reads from read address and size.
// - background data goes into the read fifo and raises the interrupt.
// - two count/address/size sets alternate, filling while the fifo drains.
// - interrupt reaches primary core, primary dma channels 20/22, secondary core.
// - four interrupt registers: status, mask, clear and masked status.
// - addresses pass unchanged or are remapped by map setting and top bit.
// - modes are general, SDRAM, host 8-bit and host 16-bit.
// - general mode drives a frame spanning 1 to 30 transactions.
// - general mode drives a port clock set by the baud divider.
// - port clock gated to transactions or free-running, as configured.
// - mode field zero selects general-purpose mode.
`timescale 1ns/1ns
module epp_port import epp_pkg::*; #(
    parameter int WF_DEPTH = 4,
    parameter int NBR_DEPTH = 8
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic priReq, // primary core request
    input wire logic priWr, // primary write when high
    input wire logic [31:0] priAddr, // primary address
    input wire logic [31:0] priWdata, // primary write data
    output logic priReady, // primary request taken
    output logic priRvalid, // primary read data valid
    output logic priErr, // primary access blocked
    input wire logic secReq, // secondary core request
    input wire logic secWr, // secondary write when high
    input wire logic [31:0] secAddr, // secondary address
    input wire logic [31:0] secWdata, // secondary write data
    output logic secReady, // secondary request taken
    output logic secRvalid, // secondary read data valid
    output logic secErr, // secondary access blocked
    output logic [31:0] rdData, // blocking read data
    input wire logic cfgWe, // configuration write strobe
    input wire logic cfgFromSec, // writer is the secondary core
    input wire logic [3:0] cfgIdx, // configuration register index
    input wire logic [31:0] cfgData, // configuration write data
    output logic cfgDenied, // configuration write refused
    input wire logic nbrPop, // take one word from the read fifo
    output logic [31:0] nbrData, // read fifo head
    output logic nbrValid, // read fifo not empty
    output logic [3:0] irqStatus, // sticky interrupt status
    output logic irqPrimary, // interrupt to primary core
    output logic irqSecondary, // interrupt to secondary core
    output logic dmaReq20, // primary dma read channel
    output logic dmaReq22, // primary dma write channel
    output logic gpSel, // general engine active
    output logic sdramSel, // SDRAM engine active
    output logic hostSel, // host engine active
    output logic hostWide, // host engine in 16-bit form
    output logic [31:0] extAddr, // address to pins
    output logic [31:0] extDout, // data to pins
    output logic extDoe_n, // data pins driven when low
    input wire logic [31:0] extDin, // data from pins
    output logic extRd, // read strobe
    output logic extWr, // write strobe
    output logic extFrame, // frame output
    output logic extClk // port clock output
);
    localparam int WFW = $clog2(WF_DEPTH);
    localparam int NBW = $clog2(NBR_DEPTH);

    logic [31:0] cfgR;
    logic [15:0] baudR, winLenR, winCnt_r, divCnt_r;
    logic [4:0] frameR, frameCnt_r;
    logic [7:0] protectR;
    logic [3:0] mapBaseR, irqMaskR, irqStat_r;
    logic [31:0] din1_r, din2_r, rdData_r;
    logic clk_r, rdPend_r, rdOwner_r, bgSet_r;
    logic [15:0] bgCnt_r [2];
    logic [31:0] bgAddr_r [2];
    logic [1:0] bgSize_r [2];
    logic [31:0] wfAddr [WF_DEPTH];
    logic [31:0] wfData [WF_DEPTH];
    logic [WFW-1:0] wfRd_r, wfWr_r;
    logic [WFW:0] wfCount_r;
    logic [31:0] nbrMem [NBR_DEPTH];
    logic [NBW-1:0] nbrRd_r, nbrWr_r;
    logic [NBW:0] nbrCount_r;
    logic [31:0] rdAddr_r;
    epp_state_t state_r;
    epp_kind_t kind_r;

    function automatic logic ownsCs(input logic [7:0] prot, input logic [1:0] cs,
        input logic who);
        ownsCs = prot[{cs, who}];
    endfunction

    function automatic logic [31:0] mapAddr(input logic [31:0] a, input logic en,
        input logic [3:0] base);
        mapAddr = (en && a[31]) ? {base, a[27:0]} : a;
    endfunction

    // arbitration and ownership
    wire [1:0] mode = cfgR[CFG_MODE_LSB +: 2];
    wire gated = cfgR[CFG_GATED_BIT];
    wire mapEn = cfgR[CFG_MAP_EN_BIT];
    wire winAct = winCnt_r != 16'h0000;
    wire grantSec = secReq && (winAct || !priReq);
    wire grantPri = priReq && !winAct;
    wire selWr = grantSec ? secWr : priWr;
    wire [31:0] selAddr = grantSec ? secAddr : priAddr;
    wire [31:0] selData = grantSec ? secWdata : priWdata;
    wire selOwns = ownsCs(protectR, selAddr[31:30], grantSec);
    wire wfFull = wfCount_r == (WFW+1)'(WF_DEPTH);
    wire wfEmpty = wfCount_r == '0;
    wire engIdle = state_r == ENG_IDLE;
    wire takeOk = !selOwns || (selWr ? (!wfFull && !rdPend_r)
        : (!rdPend_r && wfEmpty && engIdle));
    wire take = (grantPri || grantSec) && takeOk;
    assign priReady = take && !grantSec;
    assign secReady = take && grantSec;
    wire pushWf = take && selOwns && selWr;
    wire takeRd = take && selOwns && !selWr;

    // engine start, aligned to the falling point of the port clock
    wire tick = divCnt_r == baudR;
    wire slot = tick && clk_r;
    wire bgHave = bgCnt_r[bgSet_r] != 16'h0000;
    wire nbrFull = nbrCount_r == (NBW+1)'(NBR_DEPTH);
    wire startWr = engIdle && slot && !wfEmpty;
    wire startRd = engIdle && slot && wfEmpty && rdPend_r;
    wire startBg = engIdle && slot && wfEmpty && !rdPend_r && bgHave && !nbrFull;
    wire start = startWr || startRd || startBg;
    wire done = !engIdle && slot;
    wire pushNbr = done && kind_r == ENG_BG;
    wire popNbr = nbrPop && nbrCount_r != '0;
    wire clkNxt = tick ? !clk_r : clk_r;
    wire [31:0] bgStep = 32'h0000_0001 << bgSize_r[bgSet_r];
    wire other = !bgSet_r;

    // configuration: window is the secondary's, everything else the primary's
    wire winWe = cfgWe && cfgIdx == IDX_WINDOW && cfgFromSec;
    wire priWe = cfgWe && cfgIdx != IDX_WINDOW && !cfgFromSec;
    function automatic logic bgHaveOther();
        bgHaveOther = bgCnt_r[!bgSet_r] != 16'h0000;
    endfunction

    wire [3:0] irqClr = (priWe && cfgIdx == IDX_IRQ_CLEAR) ? cfgData[3:0] : 4'h0;
    wire [3:0] irqSet = {startBg && bgCnt_r[bgSet_r] == 16'h0001 && !bgHaveOther(),
        startWr && wfCount_r == (WFW+1)'(1), take && !selOwns, pushNbr};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfgR <= RST_PORT_CFG;
            baudR <= RST_BAUD;
            frameR <= FRAME_MIN;
            protectR <= RST_PROTECT;
            mapBaseR <= 4'h0;
            irqMaskR <= 4'h0;
            winLenR <= 16'h0000;
            cfgDenied <= 1'b0;
        end else begin
            cfgDenied <= cfgWe && !winWe && !priWe;
            if (winWe) winLenR <= cfgData[15:0];
            if (priWe && cfgIdx == IDX_PORT_CFG) cfgR <= cfgData;
            if (priWe && cfgIdx == IDX_BAUD) baudR <= cfgData[15:0];
            if (priWe && cfgIdx == IDX_FRAME) frameR <= cfgData[4:0];
            if (priWe && cfgIdx == IDX_PROTECT) protectR <= cfgData[7:0];
            if (priWe && cfgIdx == IDX_ADDR_MAP) mapBaseR <= cfgData[3:0];
            if (priWe && cfgIdx == IDX_IRQ_MASK) irqMaskR <= cfgData[3:0];
        end
    end

    // window opens when the secondary is granted and runs its full length
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) winCnt_r <= 16'h0000;
        else if (winAct) winCnt_r <= winCnt_r - 16'h0001;
        else if (grantSec && take && winLenR != 16'h0000) winCnt_r <= winLenR;
    end

    // write fifo
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wfRd_r <= '0;
            wfWr_r <= '0;
            wfCount_r <= '0;
        end else begin
            if (pushWf) wfWr_r <= wfWr_r + 1'b1;
            if (startWr) wfRd_r <= wfRd_r + 1'b1;
            wfCount_r <= wfCount_r + (WFW+1)'(pushWf) - (WFW+1)'(startWr);
        end
    end

    always_ff @(posedge mclk) begin
        if (pushWf) begin
            wfAddr[wfWr_r] <= mapAddr(selAddr, mapEn, mapBaseR);
            wfData[wfWr_r] <= selData;
        end
        if (pushNbr) nbrMem[nbrWr_r] <= din2_r;
    end

    // background read sets, ping-pong between set 0 and set 1
    generate
        for (genvar s = 0; s < 2; s++) begin : g_bg
            wire ld = priWe && cfgIdx == (s == 0 ? IDX_RD_COUNT0 : IDX_RD_COUNT1);
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    bgCnt_r[s] <= 16'h0000;
                    bgAddr_r[s] <= 32'h0000_0000;
                    bgSize_r[s] <= 2'h0;
                end else begin
                    if (ld) bgCnt_r[s] <= cfgData[15:0];
                    else if (startBg && bgSet_r == 1'(s)) bgCnt_r[s] <= bgCnt_r[s] - 16'h0001;
                    if (priWe && cfgIdx == (s == 0 ? IDX_RD_ADDR0 : IDX_RD_ADDR1))
                        bgAddr_r[s] <= cfgData;
                    else if (startBg && bgSet_r == 1'(s)) bgAddr_r[s] <= bgAddr_r[s] + bgStep;
                    if (priWe && cfgIdx == (s == 0 ? IDX_RD_SIZE0 : IDX_RD_SIZE1))
                        bgSize_r[s] <= cfgData[1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) bgSet_r <= 1'b0;
        else if (!bgHave && bgCnt_r[other] != 16'h0000 && engIdle) bgSet_r <= other;
    end

    // read fifo
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nbrRd_r <= '0;
            nbrWr_r <= '0;
            nbrCount_r <= '0;
        end else begin
            if (pushNbr) nbrWr_r <= nbrWr_r + 1'b1;
            if (popNbr) nbrRd_r <= nbrRd_r + 1'b1;
            nbrCount_r <= nbrCount_r + (NBW+1)'(pushNbr) - (NBW+1)'(popNbr);
        end
    end
    assign nbrData = nbrMem[nbrRd_r];
    assign nbrValid = nbrCount_r != '0;

    // pin data synchroniser; only the second stage is read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            din1_r <= 32'h0000_0000;
            din2_r <= 32'h0000_0000;
        end else begin
            din1_r <= extDin;
            din2_r <= din1_r;
        end
    end

    // blocking read bookkeeping
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdPend_r <= 1'b0;
            rdOwner_r <= 1'b0;
            rdAddr_r <= 32'h0000_0000;
            rdData_r <= 32'h0000_0000;
            priRvalid <= 1'b0;
            secRvalid <= 1'b0;
            priErr <= 1'b0;
            secErr <= 1'b0;
        end else begin
            priRvalid <= 1'b0;
            secRvalid <= 1'b0;
            priErr <= take && !selOwns && !grantSec;
            secErr <= take && !selOwns && grantSec;
            if (takeRd) begin
                rdPend_r <= 1'b1;
                rdOwner_r <= grantSec;
                rdAddr_r <= mapAddr(selAddr, mapEn, mapBaseR);
            end else if (done && kind_r == ENG_RD) begin
                rdPend_r <= 1'b0;
                rdData_r <= din2_r;
                priRvalid <= !rdOwner_r;
                secRvalid <= rdOwner_r;
            end
        end
    end
    assign rdData = rdData_r;

    // engine: each transaction lasts one port clock period, so at most one every two periods
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ENG_IDLE;
            kind_r <= ENG_WR;
            extAddr <= 32'h0000_0000;
            extDout <= 32'h0000_0000;
            extDoe_n <= 1'b1;
        end else begin
            case (state_r)
                ENG_IDLE: begin
                    if (start) begin
                        state_r <= ENG_RUN;
                        kind_r <= startWr ? ENG_WR : (startRd ? ENG_RD : ENG_BG);
                        extAddr <= startWr ? wfAddr[wfRd_r] : (startRd ? rdAddr_r
                            : mapAddr(bgAddr_r[bgSet_r], mapEn, mapBaseR));
                        extDout <= wfData[wfRd_r];
                        extDoe_n <= !startWr;
                    end
                end
                ENG_RUN: begin
                    if (done) begin
                        state_r <= ENG_IDLE;
                        extDoe_n <= 1'b1;
                    end
                end
                default: state_r <= ENG_IDLE;
            endcase
        end
    end
    assign extRd = !engIdle && kind_r != ENG_WR;
    assign extWr = !engIdle && kind_r == ENG_WR;
    assign gpSel = !engIdle && mode == MODE_GP;
    assign sdramSel = !engIdle && mode == MODE_SDRAM;
    assign hostSel = !engIdle && (mode == MODE_HOST8 || mode == MODE_HOST16);
    assign hostWide = mode == MODE_HOST16;

    // baud divider, port clock and frame; the clock runs only in general mode
    wire [4:0] frameLen = frameR < FRAME_MIN ? FRAME_MIN
        : (frameR > FRAME_MAX ? FRAME_MAX : frameR);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_r <= 16'h0000;
            clk_r <= 1'b0;
            extClk <= 1'b0;
            frameCnt_r <= 5'h00;
            extFrame <= 1'b0;
        end else begin
            divCnt_r <= tick ? 16'h0000 : divCnt_r + 16'h0001;
            clk_r <= clkNxt;
            extClk <= mode == MODE_GP && (!gated || !engIdle || start) && clkNxt;
            if (start && frameCnt_r == 5'h00 && mode == MODE_GP) frameCnt_r <= frameLen;
            else if (done && frameCnt_r != 5'h00) frameCnt_r <= frameCnt_r - 5'h01;
            extFrame <= (start && mode == MODE_GP) || (frameCnt_r != 5'h00 && !(done
                && frameCnt_r == 5'h01));
        end
    end

    // interrupt: a set in the clearing cycle wins
    wire [3:0] irqMasked = irqStat_r & irqMaskR;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_r <= 4'h0;
            irqPrimary <= 1'b0;
            irqSecondary <= 1'b0;
            dmaReq20 <= 1'b0;
            dmaReq22 <= 1'b0;
        end else begin
            irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
            irqPrimary <= |irqMasked;
            irqSecondary <= |irqMasked;
            dmaReq20 <= irqMasked[IRQ_NBR_DATA] && nbrValid;
            dmaReq22 <= irqMasked[IRQ_WF_EMPTY] && !wfFull;
        end
    end
    assign irqStatus = irqStat_r;

    // checks
    a_pri_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        priReq && secReq && !winAct |-> !secReady) else $error("secondary beat primary");
    a_window_stall: assert property (@(posedge mclk) disable iff (!rst_n)
        winAct |-> !priReady) else $error("primary taken in window");
    a_owner_block: assert property (@(posedge mclk) disable iff (!rst_n)
        priReady && !ownsCs(protectR, priAddr[31:30], 1'b0) |-> !pushWf ##1 priErr)
        else $error("unowned access not blocked");
    a_cfg_owner: assert property (@(posedge mclk) disable iff (!rst_n)
        cfgWe && cfgFromSec && cfgIdx == IDX_PORT_CFG |=> $stable(cfgR) && cfgDenied)
        else $error("secondary changed port config");
    a_steer_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        extRd || extWr |-> $onehot({gpSel, sdramSel, hostSel})) else $error("bad steering");
    a_wfifo_full: assert property (@(posedge mclk) disable iff (!rst_n)
        wfFull |-> !((priReady && priWr) || (secReady && secWr))) else $error("write overrun");
    a_read_stall: assert property (@(posedge mclk) disable iff (!rst_n)
        rdPend_r |-> !((priReady && !priWr) || (secReady && !secWr)))
        else $error("second read taken");
    a_read_drain: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(extRd) |-> $past(wfEmpty)) else $error("read passed queued write");
    a_bg_push: assert property (@(posedge mclk) disable iff (!rst_n)
        pushNbr && !popNbr |=> nbrCount_r == $past(nbrCount_r) + 1'b1 && irqStat_r[IRQ_NBR_DATA])
        else $error("background word lost");
    a_frame_len: assert property (@(posedge mclk) disable iff (!rst_n)
        frameCnt_r <= FRAME_MAX) else $error("frame too long");
    a_clk_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        gated && engIdle && $past(engIdle) && !$past(start) |-> !extClk)
        else $error("gated clock ran idle");
    c_write: cover property (@(posedge mclk) disable iff (!rst_n) pushWf ##[1:64] extWr);
    c_block_read: cover property (@(posedge mclk) disable iff (!rst_n) takeRd ##[1:64] priRvalid);
    c_bg_read: cover property (@(posedge mclk) disable iff (!rst_n) pushNbr ##[1:64] nbrPop);
    c_window: cover property (@(posedge mclk) disable iff (!rst_n) winAct && priReq);
endmodule
